/* core/cab_pkg.sv */
// Shared constants and types for the execution core and its return stack
package cab_pkg;
    localparam int PC_W = 12;
    localparam int STACK_DEPTH = 6;

    // Data space map
    localparam logic [7:0] ADDR_X = 8'h80;
    localparam logic [7:0] ADDR_ACC = 8'hff;
    localparam logic [5:0] WREG_BLOCK = 6'h20;

    // Instruction timing in core cycles
    localparam logic [2:0] CYC_REL = 3'h2;
    localparam logic [2:0] CYC_STD = 3'h4;
    localparam logic [2:0] CYC_BTB = 3'h5;
    localparam logic [2:0] CYC_CTRL = 3'h2;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;

    // Instruction lengths
    localparam logic [1:0] BYTES_1 = 2'h1;
    localparam logic [1:0] BYTES_2 = 2'h2;
    localparam logic [1:0] BYTES_3 = 2'h3;

    // Bit-test branch target sits this far before the third-byte-relative sum
    localparam logic [PC_W-1:0] BTB_ADJ = 12'h001;

    // Opcode groups, low nibble
    localparam logic [3:0] GRP_CALL = 4'h1;
    localparam logic [3:0] GRP_BTB = 4'h3;
    localparam logic [3:0] GRP_SD_INC = 4'h5;
    localparam logic [3:0] GRP_IND_X = 4'h7;
    localparam logic [3:0] GRP_JP = 4'h9;
    localparam logic [3:0] GRP_BIT = 4'hb;
    localparam logic [3:0] GRP_SD_DEC = 4'hd;
    localparam logic [3:0] GRP_MEM_Y = 4'hf;

    // Relative branch conditions, opcode bits 2:1
    localparam logic [1:0] REL_NZ = 2'h0;
    localparam logic [1:0] REL_NC = 2'h1;
    localparam logic [1:0] REL_Z = 2'h2;
    localparam logic [1:0] REL_C = 2'h3;

    // Memory operations, opcode bits 7:5
    localparam logic [2:0] ALU_LD = 3'h0;
    localparam logic [2:0] ALU_CP = 3'h1;
    localparam logic [2:0] ALU_ADD = 3'h2;
    localparam logic [2:0] ALU_INC = 3'h3;
    localparam logic [2:0] ALU_ST = 3'h4;
    localparam logic [2:0] ALU_AND = 3'h5;
    localparam logic [2:0] ALU_SUB = 3'h6;
    localparam logic [2:0] ALU_DEC = 3'h7;

    // Miscellaneous group, opcode bits 7:5
    localparam logic [2:0] MISC_CLR_A = 3'h0;
    localparam logic [2:0] MISC_CLR_RR = 3'h1;
    localparam logic [2:0] MISC_LDI_RR = 3'h2;

    // Inherent group, opcode bits 7:5
    localparam logic [2:0] INH_NOP = 3'h0;
    localparam logic [2:0] INH_RET = 3'h1;
    localparam logic [2:0] INH_INTERRUPT_RETURN = 3'h2;
    localparam logic [2:0] INH_STOP = 3'h3;
    localparam logic [2:0] INH_WAIT = 3'h4;
    localparam logic [2:0] INH_COM = 3'h5;
    localparam logic [2:0] INH_RLC = 3'h6;
    localparam logic [2:0] INH_SLA = 3'h7;

    typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP} cab_mode_t;
endpackage

/* core/cab_stack_if.sv */
// Push/pop channel between the core and its return address stack
interface cab_stack_if #(parameter int W = cab_pkg::PC_W);
    logic push;
    logic pop;
    logic [W-1:0] wdata;
    logic [W-1:0] top;
    logic full;
    logic empty;
    modport core (output push, output pop, output wdata, input top, input full, input empty);
    modport stack (input push, input pop, input wdata, output top, output full, output empty);
endinterface

/* core/cab_ret_stack.sv */
// Return address stack for calls and interrupts
module cab_ret_stack #(
    parameter int DEPTH = cab_pkg::STACK_DEPTH,
    parameter int W = cab_pkg::PC_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Core side
    cab_stack_if.stack port
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] ONE_C = CW'(1);

    if (DEPTH < 2) begin : g_bad_depth
        $error("cab_ret_stack needs at least two entries");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] top_idx;
    logic do_push;
    logic do_pop;

    assign port.full = (cnt_q == DEPTH_C);
    assign port.empty = (cnt_q == '0);
    assign do_push = port.push && !port.full;
    assign do_pop = port.pop && !port.empty && !port.push;
    assign top_idx = cnt_q - ONE_C;
    assign port.top = port.empty ? '0 : mem_q[top_idx];

    // Overflow drops the newest return address rather than corrupting older ones
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (do_push) begin
            cnt_q <= cnt_q + ONE_C; // [RL14]
        end else if (do_pop) begin
            cnt_q <= cnt_q - ONE_C;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem_q[cnt_q] <= port.wdata;
        end
    end

    a_stack_push: assert property (@(posedge ref_clk) disable iff (sys_rst)
        do_push |=> cnt_q == $past(cnt_q) + ONE_C && port.top == $past(port.wdata)) // [RL14]
        else $error("stack push lost");
endmodule // cab_ret_stack

/* core/cab_exec_core.sv */
// Execution core for arithmetic, branch, bit, control and jump instructions
// Summary of operation
// (RL1) Add, and, compare and subtract take the accumulator plus a memory or immediate operand.
// (RL2) Clear, decrement and increment can address any of the 256 data space locations.
// (RL3) Complement, rotate through carry and arithmetic shift act only on the accumulator.
// (RL4) Short relative branches on carry or zero take 2 cycles and jump only when true.
// (RL5) Short relative branches reach -15 to +16 around their own address.
// (RL6) Bit-test branches are 3 bytes, 5 cycles, reaching -126 to +129.
// (RL7) Bit-test branches copy the tested bit into carry and keep zero unchanged.
// (RL8) Bit set is 2 bytes, 4 cycles, forces the chosen bit high and keeps both flags.
// (RL9) Bit clear is 2 bytes, 4 cycles, forces the chosen bit low and keeps both flags.
// (RL10) Bit operations reach any bit of any data space location.
// (RL11) With the watchdog selected, stop is replaced by wait.
// (RL12) Jump and call take a 12-bit absolute target, 2 bytes, 4 cycles, flags kept.
// (RL13) Four working registers live at 80h to 83h, the first two also as pointers.
// (RL14) The return stack holds six 12-bit entries for calls and interrupts.
// (RL15) Interrupt return restores the flags saved at entry; plain return keeps them.
module cab_exec_core #(
    parameter int STACK_DEPTH = cab_pkg::STACK_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Program space
    output logic [cab_pkg::PC_W-1:0] prog_addr,
    input wire logic [7:0] prog_data,
    // Data space
    output logic [7:0] data_addr,
    output logic [7:0] data_wdata,
    output logic data_we,
    input wire logic [7:0] data_rdata,
    // Interrupt and low power
    input wire logic irq_req,
    input wire logic [cab_pkg::PC_W-1:0] irq_vector,
    output logic irq_ack,
    input wire logic wdg_sel,
    output logic wait_mode,
    output logic stop_mode,
    // Status
    output logic [7:0] acc,
    output logic zero_flag,
    output logic carry_flag,
    output logic instr_done
);
    localparam int PW = cab_pkg::PC_W;

    logic [PW-1:0] pc_q;
    logic [7:0] op_q, b2_q, b3_q, opnd_q, acc_q, daddr_q, dwdata_q;
    logic [7:0] wreg_q [4];
    logic [2:0] cnt_q;
    logic z_q, c_q, sz_q, sc_q, in_irq_q, dwe_q, ack_q, done_q;
    cab_pkg::cab_mode_t mode_q;

    cab_stack_if #(.W(PW)) stk ();
    cab_ret_stack #(.DEPTH(STACK_DEPTH), .W(PW)) u_stack (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .port(stk.stack)
    );

    // Decode of the latched opcode
    logic [3:0] grp;
    logic [2:0] code, bsel;
    logic is_rel, is_call, is_jp, is_btb, is_bit, is_indx, is_memy, is_sd, is_misc, is_inh;
    logic imm_x, dead_imm, is_ret;
    logic [1:0] n_bytes;
    logic [2:0] n_cyc;

    assign grp = op_q[3:0];
    assign code = op_q[7:5];
    assign bsel = {op_q[5], op_q[6], op_q[7]};
    assign is_rel = !op_q[0];
    assign is_call = (grp == cab_pkg::GRP_CALL);
    assign is_jp = (grp == cab_pkg::GRP_JP);
    assign is_btb = (grp == cab_pkg::GRP_BTB);
    assign is_bit = (grp == cab_pkg::GRP_BIT);
    assign is_indx = (grp == cab_pkg::GRP_IND_X);
    assign is_memy = (grp == cab_pkg::GRP_MEM_Y);
    assign is_sd = (grp == cab_pkg::GRP_SD_INC || grp == cab_pkg::GRP_SD_DEC) && op_q[4];
    assign is_misc = (grp == cab_pkg::GRP_SD_INC) && !op_q[4];
    assign is_inh = (grp == cab_pkg::GRP_SD_DEC) && !op_q[4];
    assign imm_x = is_indx && op_q[4];
    // Immediate forms of increment, store and decrement do not exist; run as no-ops
    assign dead_imm = imm_x && (code == cab_pkg::ALU_INC || code == cab_pkg::ALU_ST
        || code == cab_pkg::ALU_DEC);
    assign is_ret = is_inh && (code == cab_pkg::INH_RET || code == cab_pkg::INH_INTERRUPT_RETURN);

    always_comb begin
        n_bytes = cab_pkg::BYTES_1;
        n_cyc = cab_pkg::CYC_STD;
        if (is_rel) begin
            n_cyc = cab_pkg::CYC_REL; // [RL4]
        end else if (is_btb) begin
            n_cyc = cab_pkg::CYC_BTB; // [RL6]
            n_bytes = cab_pkg::BYTES_3; // [RL6]
        end else if (is_call || is_jp || is_bit || imm_x || (is_memy && op_q[4])) begin
            n_bytes = cab_pkg::BYTES_2; // [RL8] [RL9] [RL12]
        end else if (is_misc) begin
            n_bytes = (code == cab_pkg::MISC_CLR_A) ? cab_pkg::BYTES_2 : cab_pkg::BYTES_3;
        end else if (is_inh) begin
            if (code == cab_pkg::INH_SLA) begin
                n_bytes = cab_pkg::BYTES_2;
            end
            if (code < cab_pkg::INH_COM) begin
                n_cyc = cab_pkg::CYC_CTRL;
            end
        end
    end

    logic run, take_irq, start, commit, fetch_more;
    assign run = (mode_q == cab_pkg::MODE_RUN);
    assign take_irq = run && cnt_q == '0 && irq_req && !in_irq_q;
    assign start = run && cnt_q == '0 && !take_irq;
    assign commit = run && cnt_q != '0 && cnt_q == n_cyc - cab_pkg::CYC_ONE;
    assign fetch_more = run && ((cnt_q == cab_pkg::CYC_ONE && n_bytes != cab_pkg::BYTES_1)
        || (cnt_q == cab_pkg::CYC_TWO && n_bytes == cab_pkg::BYTES_3));

    // Effective address, formed while the second byte is on the program bus
    logic [7:0] ea, rd;
    logic wreg_hit;
    always_comb begin
        if (is_indx) begin
            ea = wreg_q[0]; // [RL13]
        end else if (is_memy && !op_q[4]) begin
            ea = wreg_q[1]; // [RL13]
        end else if (is_sd) begin
            ea = cab_pkg::ADDR_X | {6'h00, op_q[7:6]}; // [RL13]
        end else begin
            ea = prog_data; // [RL2] [RL10]
        end
    end
    assign wreg_hit = (daddr_q[7:2] == cab_pkg::WREG_BLOCK);
    assign rd = wreg_hit ? wreg_q[daddr_q[1:0]] :
        (daddr_q == cab_pkg::ADDR_ACC) ? acc_q : data_rdata;

    // Result of the instruction at its last cycle
    logic [8:0] sum, dif;
    logic [7:0] acc_d, mem_d, bit_mask;
    logic acc_we, mem_we, z_d, c_d, br_take, tested;
    logic [PW-1:0] rel_tgt, btb_tgt;
    assign sum = {1'b0, acc_q} + {1'b0, opnd_q};
    assign dif = {1'b0, acc_q} - {1'b0, opnd_q};
    assign bit_mask = 8'h01 << bsel;
    assign tested = opnd_q[bsel];
    assign rel_tgt = pc_q + {{(PW - 5){op_q[7]}}, op_q[7:3]}; // [RL5]
    assign btb_tgt = pc_q + {{(PW - 8){b3_q[7]}}, b3_q} - cab_pkg::BTB_ADJ; // [RL6]

    always_comb begin
        acc_we = 1'b0;
        acc_d = acc_q;
        mem_we = 1'b0;
        mem_d = opnd_q;
        z_d = z_q;
        c_d = c_q;
        br_take = 1'b0;
        if ((is_indx || is_memy) && !dead_imm) begin
            unique case (code)
                cab_pkg::ALU_LD: begin
                    acc_we = 1'b1;
                    acc_d = opnd_q;
                end
                cab_pkg::ALU_CP: begin
                    z_d = (dif[7:0] == 8'h00); // [RL1]
                    c_d = dif[8];
                end
                cab_pkg::ALU_ADD: begin
                    acc_we = 1'b1;
                    {c_d, acc_d} = sum; // [RL1]
                end
                cab_pkg::ALU_INC: begin
                    mem_we = 1'b1;
                    mem_d = opnd_q + 8'h01; // [RL2]
                end
                cab_pkg::ALU_ST: begin
                    mem_we = 1'b1;
                    mem_d = acc_q;
                end
                cab_pkg::ALU_AND: begin
                    acc_we = 1'b1;
                    acc_d = acc_q & opnd_q; // [RL1]
                    c_d = 1'b0;
                end
                cab_pkg::ALU_SUB: begin
                    acc_we = 1'b1;
                    {c_d, acc_d} = dif; // [RL1]
                end
                cab_pkg::ALU_DEC: begin
                    mem_we = 1'b1;
                    mem_d = opnd_q - 8'h01; // [RL2]
                end
            endcase
            z_d = (code == cab_pkg::ALU_CP) ? z_d : (mem_we ? mem_d == 8'h00 : acc_d == 8'h00);
        end else if (is_sd) begin
            if (op_q[5] && grp == cab_pkg::GRP_SD_INC) begin
                acc_we = 1'b1;
                acc_d = opnd_q;
                z_d = (opnd_q == 8'h00);
            end else begin
                mem_we = 1'b1;
                mem_d = op_q[5] ? acc_q :
                    (grp == cab_pkg::GRP_SD_INC) ? opnd_q + 8'h01 : opnd_q - 8'h01; // [RL2]
                z_d = (mem_d == 8'h00);
            end
        end else if (is_misc) begin
            if (code == cab_pkg::MISC_CLR_A) begin
                acc_we = 1'b1;
                acc_d = 8'h00;
                z_d = 1'b1;
                c_d = 1'b0;
            end else if (code == cab_pkg::MISC_CLR_RR || code == cab_pkg::MISC_LDI_RR) begin
                mem_we = 1'b1; // [RL2]
                mem_d = (code == cab_pkg::MISC_CLR_RR) ? 8'h00 : b3_q;
            end
        end else if (is_bit) begin
            mem_we = 1'b1; // [RL10]
            mem_d = op_q[4] ? (opnd_q | bit_mask) : (opnd_q & ~bit_mask); // [RL8] [RL9]
        end else if (is_btb) begin
            c_d = tested; // [RL7]
            br_take = (tested == op_q[4]);
        end else if (is_rel) begin
            unique case (op_q[2:1])
                cab_pkg::REL_NZ: br_take = !z_q; // [RL4]
                cab_pkg::REL_NC: br_take = !c_q;
                cab_pkg::REL_Z: br_take = z_q;
                cab_pkg::REL_C: br_take = c_q;
            endcase
        end else if (is_inh) begin
            acc_we = (code >= cab_pkg::INH_COM); // [RL3]
            unique case (code)
                cab_pkg::INH_COM: {c_d, acc_d} = {acc_q[7], ~acc_q};
                cab_pkg::INH_RLC: {c_d, acc_d} = {acc_q, c_q};
                cab_pkg::INH_SLA: {c_d, acc_d} = {acc_q, 1'b0};
                cab_pkg::INH_INTERRUPT_RETURN: {z_d, c_d} = {sz_q, sc_q}; // [RL15]
                default: ;
            endcase
            if (acc_we) begin
                z_d = (acc_d == 8'h00);
            end
        end
    end

    // Return stack traffic
    assign stk.push = take_irq || (commit && is_call); // [RL14]
    assign stk.pop = commit && is_ret;
    assign stk.wdata = pc_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_q <= '0;
        end else if (take_irq) begin
            pc_q <= irq_vector;
        end else if (commit && (is_call || is_jp)) begin
            pc_q <= {op_q[7:4], b2_q}; // [RL12]
        end else if (commit && is_ret) begin
            pc_q <= stk.top;
        end else if (commit && br_take) begin
            pc_q <= is_btb ? btb_tgt : rel_tgt; // [RL4] [RL6]
        end else if (start || fetch_more) begin
            pc_q <= pc_q + PW'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= cab_pkg::CYC_ONE;
        end else if (commit) begin
            cnt_q <= '0;
        end else if (run && cnt_q != '0) begin
            cnt_q <= cnt_q + cab_pkg::CYC_ONE;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            op_q <= 8'h00;
            b2_q <= 8'h00;
            b3_q <= 8'h00;
            opnd_q <= 8'h00;
        end else if (start) begin
            op_q <= prog_data;
        end else if (run && cnt_q == cab_pkg::CYC_ONE) begin
            b2_q <= prog_data;
        end else if (run && cnt_q == cab_pkg::CYC_TWO) begin
            b3_q <= prog_data;
            opnd_q <= imm_x ? b2_q : rd; // [RL1]
        end
    end

    // Accumulator, and working registers written through their data addresses
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q <= 8'h00;
        end else if (commit && acc_we) begin
            acc_q <= acc_d;
        end else if (commit && mem_we && daddr_q == cab_pkg::ADDR_ACC) begin
            acc_q <= mem_d;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++) begin
                wreg_q[i] <= 8'h00;
            end
        end else if (commit && mem_we && wreg_hit) begin
            wreg_q[daddr_q[1:0]] <= mem_d; // [RL13]
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            z_q <= 1'b0;
            c_q <= 1'b0;
        end else if (commit) begin
            z_q <= z_d;
            c_q <= c_d;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sz_q <= 1'b0;
            sc_q <= 1'b0;
            in_irq_q <= 1'b0;
        end else if (take_irq) begin
            sz_q <= z_q; // [RL15]
            sc_q <= c_q;
            in_irq_q <= 1'b1;
        end else if (commit && is_inh && code == cab_pkg::INH_INTERRUPT_RETURN) begin
            in_irq_q <= 1'b0;
        end
    end

    // External address is held through the following cycle so a write lands cleanly
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            daddr_q <= 8'h00;
            dwdata_q <= 8'h00;
            dwe_q <= 1'b0;
        end else begin
            if (run && cnt_q == cab_pkg::CYC_ONE) begin
                daddr_q <= ea;
            end
            dwe_q <= commit && mem_we && !wreg_hit && daddr_q != cab_pkg::ADDR_ACC;
            if (commit && mem_we) begin
                dwdata_q <= mem_d;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= cab_pkg::MODE_RUN;
        end else if (!run && irq_req) begin
            mode_q <= cab_pkg::MODE_RUN;
        end else if (commit && is_inh && code == cab_pkg::INH_WAIT) begin
            mode_q <= cab_pkg::MODE_WAIT;
        end else if (commit && is_inh && code == cab_pkg::INH_STOP) begin
            mode_q <= wdg_sel ? cab_pkg::MODE_WAIT : cab_pkg::MODE_STOP; // [RL11]
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            ack_q <= take_irq;
            done_q <= commit;
        end
    end

    assign prog_addr = pc_q;
    assign data_addr = daddr_q;
    assign data_wdata = dwdata_q;
    assign data_we = dwe_q;
    assign irq_ack = ack_q;
    assign wait_mode = (mode_q == cab_pkg::MODE_WAIT);
    assign stop_mode = (mode_q == cab_pkg::MODE_STOP);
    assign acc = acc_q;
    assign zero_flag = z_q;
    assign carry_flag = c_q;
    assign instr_done = done_q;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_rel_cycles: assert property (start && !prog_data[0] |=> ##1 done_q) // [RL4]
        else $error("short branch not two cycles");
    a_rel_target: assert property (commit && is_rel && br_take |=> pc_q == $past(rel_tgt)) // [RL5]
        else $error("short branch target wrong");
    a_btb_cycles: assert property (start && prog_data[3:0] == cab_pkg::GRP_BTB |=> ##4 done_q) // [RL6]
        else $error("bit-test branch not five cycles");
    a_btb_carry: assert property (commit && is_btb |=> c_q == tested && $stable(z_q)) // [RL7]
        else $error("bit-test carry wrong");
    a_bit_set: assert property (commit && is_bit && op_q[4] |=> $stable(z_q) && $stable(c_q)
        && (!data_we || data_wdata[bsel])) // [RL8]
        else $error("bit set wrong");
    a_bit_clear: assert property (commit && is_bit && !op_q[4] |=> $stable(z_q)
        && $stable(c_q) && (!data_we || !data_wdata[bsel])) // [RL9]
        else $error("bit clear wrong");
    a_stop_subst: assert property (commit && is_inh && code == cab_pkg::INH_STOP && wdg_sel
        |=> wait_mode && !stop_mode) // [RL11]
        else $error("stop not replaced by wait");
    a_jump_flags: assert property (commit && (is_jp || is_call) |=> $stable(z_q) && $stable(c_q)
        && pc_q == {op_q[7:4], b2_q}) // [RL12]
        else $error("jump target or flags wrong");
    a_acc_complement: assert property (commit && is_inh && code == cab_pkg::INH_COM
        |=> acc_q == ~$past(acc_q) && !data_we) // [RL3]
        else $error("complement left the accumulator");
    a_interrupt_return_flags: assert property (commit && is_inh && code == cab_pkg::INH_INTERRUPT_RETURN
        |=> z_q == $past(sz_q) && c_q == $past(sc_q)) // [RL15]
        else $error("flags not restored");

    c_rel_taken: cover property (commit && is_rel && br_take);
    c_btb_taken: cover property (commit && is_btb && br_take);
    c_irq_entry: cover property (take_irq ##[1:40] (commit && is_inh && code == cab_pkg::INH_INTERRUPT_RETURN));
    c_stop_as_wait: cover property (commit && is_inh && code == cab_pkg::INH_STOP && wdg_sel);
endmodule // cab_exec_core

/* testbench/core_alu_branch_control_ops_tb.sv */
// Self-checking bench for the execution core
module core_alu_branch_control_ops_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic irq_req = 1'b0;
    logic wdg_sel = 1'b0;
    logic [11:0] irq_vector = 12'h000;
    logic [11:0] prog_addr;
    logic [7:0] prog_data, data_addr, data_wdata, data_rdata, acc;
    logic data_we, irq_ack, wait_mode, stop_mode, zero_flag, carry_flag, instr_done;
    logic [7:0] pmem [4096];
    logic [7:0] dmem [256];
    int num_errors = 0;
    int num_checks = 0;
    int gap = 0;
    int writes = 0;
    int gaps [$];

    always #4 ref_clk = ~ref_clk;

    // Memories answer in the same cycle, as the core expects
    assign prog_data = pmem[prog_addr];
    assign data_rdata = dmem[data_addr];

    cab_exec_core dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .prog_addr(prog_addr),
        .prog_data(prog_data), .data_addr(data_addr), .data_wdata(data_wdata),
        .data_we(data_we), .data_rdata(data_rdata), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_ack(irq_ack), .wdg_sel(wdg_sel),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .acc(acc), .zero_flag(zero_flag),
        .carry_flag(carry_flag), .instr_done(instr_done));

    // Gap between completions equals the cycle count of the later instruction
    always @(posedge ref_clk) begin
        gap++;
        if (instr_done === 1'b1) begin
            gaps.push_back(gap);
            gap = 0;
        end
        if (data_we === 1'b1) begin
            dmem[data_addr] <= data_wdata;
            writes++;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic load(input logic [7:0] img [$]);
        foreach (pmem[i]) pmem[i] = 8'h00;
        foreach (dmem[i]) dmem[i] = 8'h00;
        foreach (img[i]) pmem[i] = img[i];
    endtask

    task automatic do_reset(input logic wdg);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        wdg_sel <= wdg;
        irq_req <= 1'b0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        gaps.delete();
        gap = 0;
        writes = 0;
    endtask

    task automatic run_alu_branch();
        int exp_gap [9] = '{4, 2, 2, 4, 4, 4, 4, 5, 4};
        load('{8'h17, 8'h05, 8'h57, 8'hfb, 8'h16, 8'h17, 8'haa, 8'h08, 8'h17, 8'h33, 8'h1b,
            8'h40, 8'heb, 8'h40, 8'h7f, 8'h41, 8'h83, 8'h40, 8'h03, 8'h17, 8'h77, 8'h09, 8'h15});
        dmem[8'h40] = 8'h80;
        dmem[8'h41] = 8'hff;
        do_reset(1'b0);
        repeat (60) @(negedge ref_clk);
        for (int i = 0; i < 9; i++) begin
            check(gaps[i + 1], exp_gap[i], "cycles");
        end
        check(acc, 8'h33, "acc");
        check(zero_flag, 1'b1, "zero");
        check(carry_flag, 1'b0, "carry");
        check(dmem[8'h40], 8'h01, "bit ops");
        check(dmem[8'h41], 8'h00, "inc");
        check(writes, 3, "writes");
    endtask

    task automatic run_stop_irq();
        int n;
        for (int w = 0; w < 2; w++) begin
            load('{8'h17, 8'hf0, 8'had, 8'h6d, 8'h09, 8'h04});
            pmem[12'h020] = 8'h17;
            pmem[12'h022] = 8'h4d;
            do_reset(w[0]);
            repeat (30) @(negedge ref_clk);
            check(wait_mode, w[0], "wait");
            check(stop_mode, !w[0], "stop");
            check(acc, 8'h0f, "com");
            check(writes, 0, "acc writes");
            @(posedge ref_clk);
            irq_vector <= 12'h020;
            irq_req <= 1'b1;
            for (n = 0; n < 20 && irq_ack !== 1'b1; n++) @(negedge ref_clk);
            check(irq_ack, 1'b1, "ack");
            @(posedge ref_clk);
            irq_req <= 1'b0;
            repeat (30) @(negedge ref_clk);
            // Handler set zero; the return must bring back the entry flags
            check(zero_flag, 1'b0, "interrupt_return zero");
            check(carry_flag, 1'b1, "interrupt_return carry");
            check(wait_mode | stop_mode, 1'b0, "halt left");
        end
    endtask

    // Call into a subtract that reads a working register, return, then carry through shifts
    task automatic run_call_sd();
        load('{8'h17, 8'hc3, 8'h3d, 8'h01, 8'h10, 8'h37, 8'h10, 8'hcd, 8'hed, 8'h00, 8'h09,
            8'h0a});
        pmem[12'h010] = 8'hdf;
        pmem[12'h011] = 8'h80;
        pmem[12'h012] = 8'h2d;
        do_reset(1'b0);
        repeat (60) @(negedge ref_clk);
        check(gaps[2], 4, "call cycles");
        check(gaps[4], 2, "ret cycles");
        check(acc, 8'h02, "call and shifts");
        check(carry_flag, 1'b0, "shift carry");
        check(zero_flag, 1'b0, "shift zero");
        check(writes, 0, "working regs internal");
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        run_alu_branch();
        run_stop_irq();
        run_call_sd();
        tally_and_finish();
    end
endmodule // core_alu_branch_control_ops_tb
